// [hw/add_logic_cfg.svh]
// Constants for the add, add-quick, add-with-extend and conjunction unit
`ifndef ADD_LOGIC_CFG_SVH
`define ADD_LOGIC_CFG_SVH

// Opcode group codes in bits 15..12
`define GRP_QUICK 4'h5
`define GRP_EXTEND 4'hD
`define GRP_AND 4'hC
// Upper opcode byte of the add-immediate form
`define IMM_ADD_HI 8'h06

// Field positions
`define OPC_GRP_MSB 15
`define OPC_GRP_LSB 12
`define OPC_HI_MSB 11
`define OPC_HI_LSB 9
`define OPC_MODE_BIT 8
`define OPC_SIZE_MSB 7
`define OPC_SIZE_LSB 6
`define OPC_EAM_MSB 5
`define OPC_EAM_LSB 3
`define OPC_EAR_MSB 2
`define OPC_EAR_LSB 0
`define OPC_RM_BIT 3

// Size codes
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

// Effective address modes and extended-mode registers
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_EXT 3'h7
`define EXT_ABS_W 3'h0
`define EXT_ABS_L 3'h1
`define EXT_IMM 3'h4

// Quick addend for a zero field
`define QUICK_ZERO_VAL 32'h00000008

// Predecrement steps
`define DEC_BYTE 32'h00000001
`define DEC_WORD 32'h00000002
`define DEC_LONG 32'h00000004

// Condition code bit positions
`define CCR_X 4
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0

// Reset values
`define CCR_RST 5'h00
`define REG_RST 32'h00000000

`endif

// [hw/add_logic_pkg.sv]
// Types for the add, add-quick, add-with-extend and conjunction unit
package add_logic_pkg;
   typedef enum logic [2:0] {
      OP_NONE,
      OP_IMM,
      OP_QUICK,
      OP_EXTEND,
      OP_AND
   } op_kind_t;

   typedef enum logic [1:0] {
      SZ_BYTE,
      SZ_WORD,
      SZ_LONG
   } size_t;
endpackage : add_logic_pkg

// [hw/sized_alu.sv]
// Sized adder and conjunction with condition flag outputs
`timescale 1ns/1ps
module sized_alu #(
   parameter int DATA_W = 32
) (
   // Operands
   input wire logic [DATA_W-1:0] a,
   input wire logic [DATA_W-1:0] b,
   input wire logic cin,
   input wire add_logic_pkg::size_t size,
   input wire logic and_op,
   // Result and flags
   output logic [DATA_W-1:0] res,
   output logic n,
   output logic z,
   output logic v,
   output logic c
);
   if (DATA_W != 32) begin : g_chk
      $error("sized_alu supports only 32-bit data");
   end

   logic [32:0] sum;
   logic [31:0] mask;
   logic [31:0] raw;
   logic [31:0] carry_bits;
   int msb;

   always_comb begin
      sum = {1'b0, a} + {1'b0, b} + {32'h00000000, cin};
      case (size)
         add_logic_pkg::SZ_BYTE: begin
            mask = 32'h000000FF;
            msb = 7;
         end
         add_logic_pkg::SZ_WORD: begin
            mask = 32'h0000FFFF;
            msb = 15;
         end
         default: begin
            mask = 32'hFFFFFFFF;
            msb = 31;
         end
      endcase
      raw = and_op ? (a & b) : sum[31:0];
      res = raw & mask;
      // Carry out of the sized msb
      carry_bits = (a & b) | ((a | b) & ~sum[31:0]);
      n = res[msb];
      z = (res == 32'h00000000);
      v = !and_op && (a[msb] == b[msb]) && (res[msb] != a[msb]);
      c = !and_op && carry_bits[msb];
   end
endmodule : sized_alu

// [hw/add_quick_extend_logic_ops.sv]
// Decode and execute unit for add-immediate, add-quick, add-with-extend and conjunction
//
// Summary of operation
// [RULE_01] Add-immediate data: byte from low of ext word, word whole, long two words.
// [RULE_02] Quick field gives addend 1..8; zero field means eight.
// [RULE_03] Size field 00 byte, 01 word, 10 long for the three additions.
// [RULE_04] Quick add to address register: word or long only, flags unchanged.
// [RULE_05] Quick add to address register writes the full 32-bit register.
// [RULE_06] Quick add destination must be alterable; address direct allowed, no immediate/PC.
// [RULE_07] Additions set N, V, C from result; X copies C.
// [RULE_08] Quick and immediate additions set Z on zero sized result, else clear.
// [RULE_09] Extend add computes source plus destination plus X at selected width.
// [RULE_10] Form bit 0 register to register, 1 memory to memory by predecrement.
// [RULE_11] Upper field names destination, lower field source, register or address.
// [RULE_12] Extend add leaves Z unchanged on zero result; software presets it.
// [RULE_13] Conjunction of source and destination, sized; no address register operand.
// [RULE_14] Conjunction sets N from msb, Z on zero, clears V and C, keeps X.
// [RULE_15] Conjunction op-mode 0xx writes data register, 1xx writes effective address.
// [RULE_16] Conjunction source from address: data modes only, immediate and PC allowed.
// [RULE_17] Conjunction destination address: alterable memory modes only.
// [RULE_18] Software uses data-register op-modes when the destination is a register.
// [RULE_19] Conjunction register field picks one of eight data registers.
// [RULE_20] Extend add clears Z when the sized result is nonzero.
// [RULE_21] Group decode: quick 0101 bit8 clear; extend 1101 bit8 set; and 1100.
`timescale 1ns/1ps
`include "add_logic_cfg.svh"
module add_quick_extend_logic_ops #(
   parameter int DATA_W = 32,
   parameter int NUM_REGS = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Instruction and extension words
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [15:0] ext_word0,
   input wire logic [15:0] ext_word1,
   // Memory operands fetched by the addressing logic
   input wire logic [DATA_W-1:0] mem_src_data,
   input wire logic [DATA_W-1:0] mem_dst_data,
   // Register load and read port
   input wire logic reg_wr_en,
   input wire logic reg_wr_addr_sel,
   input wire logic [2:0] reg_wr_idx,
   input wire logic [DATA_W-1:0] reg_wr_data,
   input wire logic reg_rd_addr_sel,
   input wire logic [2:0] reg_rd_idx,
   output logic [DATA_W-1:0] reg_rd_data_q,
   // Execution results
   output logic done_q,
   output logic illegal_q,
   output logic mem_wr_q,
   output logic [DATA_W-1:0] result_q,
   output logic [DATA_W-1:0] src_addr_q,
   output logic [DATA_W-1:0] dst_addr_q,
   output logic [4:0] ccr_q
);
   if (DATA_W != 32 || NUM_REGS != 8) begin : g_chk
      $error("unit supports 32-bit data and eight registers only");
   end

   function automatic logic ea_alterable(input logic [2:0] mode, input logic [2:0] rg);
      ea_alterable = (mode != `MODE_EXT) || (rg == `EXT_ABS_W) || (rg == `EXT_ABS_L);
   endfunction : ea_alterable

   function automatic logic ea_data_mode(input logic [2:0] mode, input logic [2:0] rg);
      ea_data_mode = (mode != `MODE_AREG) && ((mode != `MODE_EXT) || (rg <= `EXT_IMM));
   endfunction : ea_data_mode

   function automatic add_logic_pkg::size_t to_size(input logic [1:0] code);
      case (code)
         `SIZE_BYTE: to_size = add_logic_pkg::SZ_BYTE;
         `SIZE_WORD: to_size = add_logic_pkg::SZ_WORD;
         default: to_size = add_logic_pkg::SZ_LONG;
      endcase
   endfunction : to_size

   function automatic logic [31:0] imm_val(input add_logic_pkg::size_t sz,
                                           input logic [15:0] w0, input logic [15:0] w1);
      case (sz)
         add_logic_pkg::SZ_BYTE: imm_val = {24'h000000, w0[7:0]};
         add_logic_pkg::SZ_WORD: imm_val = {16'h0000, w0};
         default: imm_val = {w0, w1};
      endcase
   endfunction : imm_val

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input add_logic_pkg::size_t sz);
      case (sz)
         add_logic_pkg::SZ_BYTE: merge = {old[31:8], val[7:0]};
         add_logic_pkg::SZ_WORD: merge = {old[31:16], val[15:0]};
         default: merge = val;
      endcase
   endfunction : merge

   function automatic logic [31:0] dec_step(input add_logic_pkg::size_t sz);
      case (sz)
         add_logic_pkg::SZ_BYTE: dec_step = `DEC_BYTE;
         add_logic_pkg::SZ_WORD: dec_step = `DEC_WORD;
         default: dec_step = `DEC_LONG;
      endcase
   endfunction : dec_step

   // Instruction fields
   logic [2:0] ea_mode;
   logic [2:0] ea_reg;
   logic [2:0] reg_hi;
   logic [1:0] size_code;
   logic [2:0] opmode;
   assign ea_mode = instr_word[`OPC_EAM_MSB:`OPC_EAM_LSB];
   assign ea_reg = instr_word[`OPC_EAR_MSB:`OPC_EAR_LSB];
   assign reg_hi = instr_word[`OPC_HI_MSB:`OPC_HI_LSB];
   assign size_code = instr_word[`OPC_SIZE_MSB:`OPC_SIZE_LSB];
   assign opmode = instr_word[`OPC_MODE_BIT:`OPC_SIZE_LSB];

   // State
   logic [DATA_W-1:0] d_regs_q [NUM_REGS];
   logic [DATA_W-1:0] d_regs_d [NUM_REGS];
   logic [DATA_W-1:0] a_regs_q [NUM_REGS];
   logic [DATA_W-1:0] a_regs_d [NUM_REGS];
   logic [4:0] ccr_d;
   logic done_d;
   logic illegal_d;
   logic mem_wr_d;
   logic [DATA_W-1:0] result_d;
   logic [DATA_W-1:0] src_addr_d;
   logic [DATA_W-1:0] dst_addr_d;
   logic [DATA_W-1:0] reg_rd_data_d;

   // Decode results
   add_logic_pkg::op_kind_t op_kind;
   add_logic_pkg::size_t op_size;
   logic legal;
   logic [31:0] addend;
   logic [31:0] opa;
   logic [31:0] opb;
   logic alu_cin;
   logic alu_and;
   logic [31:0] alu_res;
   logic alu_n;
   logic alu_z;
   logic alu_v;
   logic alu_c;
   logic [31:0] ay_new;
   logic [31:0] ax_new;

   // Decode, legality and operand selection
   always_comb begin
      op_kind = add_logic_pkg::OP_NONE;
      op_size = to_size(size_code);
      legal = 1'b0;
      addend = (reg_hi == 3'h0) ? `QUICK_ZERO_VAL : {29'h0, reg_hi}; // RULE_02
      opa = 32'h00000000;
      opb = 32'h00000000;
      alu_cin = 1'b0;
      alu_and = 1'b0;
      if (instr_word[15:8] == `IMM_ADD_HI) begin
         op_kind = add_logic_pkg::OP_IMM;
         legal = (size_code != 2'h3) && ea_alterable(ea_mode, ea_reg)
                 && (ea_mode != `MODE_AREG); // RULE_03
         opb = imm_val(op_size, ext_word0, ext_word1); // RULE_01
      end else if (instr_word[`OPC_GRP_MSB:`OPC_GRP_LSB] == `GRP_QUICK
                   && !instr_word[`OPC_MODE_BIT]) begin // RULE_21
         op_kind = add_logic_pkg::OP_QUICK;
         legal = (size_code != 2'h3) && ea_alterable(ea_mode, ea_reg) // RULE_06
                 && !(ea_mode == `MODE_AREG && size_code == `SIZE_BYTE); // RULE_04
         opb = addend;
      end else if (instr_word[`OPC_GRP_MSB:`OPC_GRP_LSB] == `GRP_EXTEND
                   && instr_word[`OPC_MODE_BIT] && instr_word[5:4] == 2'h0) begin // RULE_21
         op_kind = add_logic_pkg::OP_EXTEND;
         legal = (size_code != 2'h3); // RULE_03
         alu_cin = ccr_q[`CCR_X]; // RULE_09
         if (instr_word[`OPC_RM_BIT]) begin // RULE_10
            opa = mem_dst_data;
            opb = mem_src_data;
         end else begin
            opa = d_regs_q[reg_hi]; // RULE_11
            opb = d_regs_q[ea_reg]; // RULE_11
         end
      end else if (instr_word[`OPC_GRP_MSB:`OPC_GRP_LSB] == `GRP_AND) begin // RULE_21
         op_kind = add_logic_pkg::OP_AND;
         op_size = to_size(opmode[1:0]); // RULE_15
         alu_and = 1'b1; // RULE_13
         if (opmode[2]) begin
            legal = (opmode[1:0] != 2'h3) && ea_alterable(ea_mode, ea_reg)
                    && (ea_mode != `MODE_DREG) && (ea_mode != `MODE_AREG); // RULE_17
            opa = mem_dst_data;
            opb = d_regs_q[reg_hi]; // RULE_19
         end else begin
            legal = (opmode[1:0] != 2'h3) && ea_data_mode(ea_mode, ea_reg); // RULE_16
            opa = d_regs_q[reg_hi]; // RULE_19
            if (ea_mode == `MODE_DREG) begin
               opb = d_regs_q[ea_reg];
            end else if (ea_mode == `MODE_EXT && ea_reg == `EXT_IMM) begin
               opb = imm_val(op_size, ext_word0, ext_word1);
            end else begin
               opb = mem_src_data;
            end
         end
      end
      // Destination operand of the immediate and quick additions
      if (op_kind == add_logic_pkg::OP_IMM || op_kind == add_logic_pkg::OP_QUICK) begin
         if (ea_mode == `MODE_DREG) begin
            opa = d_regs_q[ea_reg];
         end else if (ea_mode == `MODE_AREG) begin
            opa = a_regs_q[ea_reg];
         end else begin
            opa = mem_dst_data;
         end
      end
      // Predecrement addresses; source first, then destination
      ay_new = a_regs_q[ea_reg] - dec_step(op_size); // RULE_10
      ax_new = ((reg_hi == ea_reg) ? ay_new : a_regs_q[reg_hi]) - dec_step(op_size);
   end

   sized_alu #(
      .DATA_W(DATA_W)
   ) sized_alu_inst (
      .a(opa),
      .b(opb),
      .cin(alu_cin),
      .size(op_size),
      .and_op(alu_and),
      .res(alu_res),
      .n(alu_n),
      .z(alu_z),
      .v(alu_v),
      .c(alu_c)
   );

   // Next state of registers, flags and results
   always_comb begin
      d_regs_d = d_regs_q;
      a_regs_d = a_regs_q;
      ccr_d = ccr_q;
      result_d = result_q;
      src_addr_d = src_addr_q;
      dst_addr_d = dst_addr_q;
      done_d = 1'b0;
      illegal_d = 1'b0;
      mem_wr_d = 1'b0;
      reg_rd_data_d = reg_rd_addr_sel ? a_regs_q[reg_rd_idx] : d_regs_q[reg_rd_idx];
      if (reg_wr_en) begin
         if (reg_wr_addr_sel) begin
            a_regs_d[reg_wr_idx] = reg_wr_data;
         end else begin
            d_regs_d[reg_wr_idx] = reg_wr_data;
         end
      end
      if (instr_valid) begin
         done_d = 1'b1;
         illegal_d = !legal;
         if (legal) begin
            case (op_kind)
               add_logic_pkg::OP_IMM, add_logic_pkg::OP_QUICK: begin
                  if (ea_mode == `MODE_AREG) begin
                     a_regs_d[ea_reg] = a_regs_q[ea_reg] + addend; // RULE_05
                  end else begin
                     if (ea_mode == `MODE_DREG) begin
                        d_regs_d[ea_reg] = merge(d_regs_q[ea_reg], alu_res, op_size);
                     end else begin
                        mem_wr_d = 1'b1;
                        result_d = alu_res;
                     end
                     ccr_d[`CCR_N] = alu_n; // RULE_07
                     ccr_d[`CCR_V] = alu_v; // RULE_07
                     ccr_d[`CCR_C] = alu_c; // RULE_07
                     ccr_d[`CCR_X] = alu_c; // RULE_07
                     ccr_d[`CCR_Z] = alu_z; // RULE_08
                  end
               end
               add_logic_pkg::OP_EXTEND: begin
                  if (instr_word[`OPC_RM_BIT]) begin // RULE_10
                     a_regs_d[ea_reg] = ay_new;
                     a_regs_d[reg_hi] = ax_new;
                     src_addr_d = ay_new;
                     dst_addr_d = ax_new;
                     mem_wr_d = 1'b1;
                     result_d = alu_res; // RULE_09
                  end else begin
                     d_regs_d[reg_hi] = merge(d_regs_q[reg_hi], alu_res, op_size); // RULE_09
                  end
                  ccr_d[`CCR_N] = alu_n; // RULE_07
                  ccr_d[`CCR_V] = alu_v; // RULE_07
                  ccr_d[`CCR_C] = alu_c; // RULE_07
                  ccr_d[`CCR_X] = alu_c; // RULE_07
                  if (!alu_z) begin
                     ccr_d[`CCR_Z] = 1'b0; // RULE_20 RULE_12
                  end
               end
               add_logic_pkg::OP_AND: begin
                  if (opmode[2]) begin // RULE_15
                     mem_wr_d = 1'b1;
                     result_d = alu_res; // RULE_13
                  end else begin
                     d_regs_d[reg_hi] = merge(d_regs_q[reg_hi], alu_res, op_size); // RULE_15
                  end
                  ccr_d[`CCR_N] = alu_n; // RULE_14
                  ccr_d[`CCR_Z] = alu_z; // RULE_14
                  ccr_d[`CCR_V] = 1'b0; // RULE_14
                  ccr_d[`CCR_C] = 1'b0; // RULE_14
               end
               default: begin
                  illegal_d = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            d_regs_q[i] <= `REG_RST;
            a_regs_q[i] <= `REG_RST;
         end
         ccr_q <= `CCR_RST;
         result_q <= `REG_RST;
         src_addr_q <= `REG_RST;
         dst_addr_q <= `REG_RST;
         reg_rd_data_q <= `REG_RST;
         done_q <= 1'b0;
         illegal_q <= 1'b0;
         mem_wr_q <= 1'b0;
      end else begin
         d_regs_q <= d_regs_d;
         a_regs_q <= a_regs_d;
         ccr_q <= ccr_d;
         result_q <= result_d;
         src_addr_q <= src_addr_d;
         dst_addr_q <= dst_addr_d;
         reg_rd_data_q <= reg_rd_data_d;
         done_q <= done_d;
         illegal_q <= illegal_d;
         mem_wr_q <= mem_wr_d;
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic run;
   assign run = instr_valid && legal;

   a_imm_byte: assert property (instr_valid && op_kind == add_logic_pkg::OP_IMM // RULE_01
      && size_code == `SIZE_BYTE |-> opb == {24'h000000, ext_word0[7:0]})
      else $error("byte immediate not taken from low byte");
   a_quick_addend: assert property (instr_valid && op_kind == add_logic_pkg::OP_QUICK // RULE_02
      |-> opb >= 32'h1 && opb <= 32'h8 && ((reg_hi == 3'h0) == (opb == 32'h8)))
      else $error("quick addend out of range");
   a_size_byte: assert property (run && op_kind != add_logic_pkg::OP_AND // RULE_03
      && op_kind != add_logic_pkg::OP_EXTEND && ea_mode == `MODE_DREG
      && size_code == `SIZE_BYTE
      |=> d_regs_q[$past(ea_reg)][31:8] == $past(d_regs_q[ea_reg][31:8]))
      else $error("byte addition changed upper register bits");
   a_quick_ccr_hold: assert property (run && op_kind == add_logic_pkg::OP_QUICK // RULE_04
      && ea_mode == `MODE_AREG |=> $stable(ccr_q))
      else $error("flags changed on address register quick add");
   a_quick_full_reg: assert property (run && op_kind == add_logic_pkg::OP_QUICK // RULE_05
      && ea_mode == `MODE_AREG && !reg_wr_en
      |=> a_regs_q[$past(ea_reg)] == $past(a_regs_q[ea_reg]) + $past(addend))
      else $error("address register not fully updated");
   a_quick_no_pc: assert property (instr_valid && op_kind == add_logic_pkg::OP_QUICK // RULE_06
      && ea_mode == `MODE_EXT && ea_reg >= 3'h2 |=> illegal_q && !mem_wr_q)
      else $error("quick add accepted a non-alterable mode");
   a_add_x_copy: assert property (run && op_kind != add_logic_pkg::OP_AND // RULE_07
      && ea_mode != `MODE_AREG |=> ccr_q[`CCR_X] == ccr_q[`CCR_C])
      else $error("extend flag differs from carry");
   a_imm_zero: assert property (run && op_kind == add_logic_pkg::OP_IMM // RULE_08
      |=> ccr_q[`CCR_Z] == $past(alu_z))
      else $error("zero flag wrong after immediate add");
   a_extend_zero: assert property (run && op_kind == add_logic_pkg::OP_EXTEND // RULE_12
      |=> ccr_q[`CCR_Z] == ($past(ccr_q[`CCR_Z]) && $past(alu_z)))
      else $error("extend add zero flag rule broken");
   a_and_flags: assert property (run && op_kind == add_logic_pkg::OP_AND // RULE_14
      |=> !ccr_q[`CCR_V] && !ccr_q[`CCR_C] && ccr_q[`CCR_X] == $past(ccr_q[`CCR_X]))
      else $error("conjunction flags wrong");
   a_and_to_mem: assert property (run && op_kind == add_logic_pkg::OP_AND // RULE_15
      && opmode[2] |=> mem_wr_q && done_q)
      else $error("conjunction to address did not write memory");
   a_and_no_areg: assert property (instr_valid && op_kind == add_logic_pkg::OP_AND // RULE_16
      && ea_mode == `MODE_AREG |=> illegal_q)
      else $error("conjunction accepted address register");

   c_quick_areg: cover property (run && op_kind == add_logic_pkg::OP_QUICK
      && ea_mode == `MODE_AREG);
   c_extend_mem: cover property (run && op_kind == add_logic_pkg::OP_EXTEND
      && instr_word[`OPC_RM_BIT]);
   c_and_imm: cover property (run && op_kind == add_logic_pkg::OP_AND
      && ea_mode == `MODE_EXT && ea_reg == `EXT_IMM);
   c_illegal: cover property (instr_valid && !legal);
endmodule : add_quick_extend_logic_ops

// [tb/add_quick_extend_logic_ops_tb.sv]
// Testbench for the add, add-quick, add-with-extend and conjunction unit
`timescale 1ns/1ps
module add_quick_extend_logic_ops_tb;
   logic clk;
   logic sys_rst;
   logic instr_valid;
   logic [15:0] instr_word;
   logic [15:0] ext_word0;
   logic [15:0] ext_word1;
   logic [31:0] mem_src_data;
   logic [31:0] mem_dst_data;
   logic reg_wr_en;
   logic reg_wr_addr_sel;
   logic [2:0] reg_wr_idx;
   logic [31:0] reg_wr_data;
   logic reg_rd_addr_sel;
   logic [2:0] reg_rd_idx;
   logic [31:0] reg_rd_data_q;
   logic done_q;
   logic illegal_q;
   logic mem_wr_q;
   logic [31:0] result_q;
   logic [31:0] src_addr_q;
   logic [31:0] dst_addr_q;
   logic [4:0] ccr_q;
   int err_total;
   int checks_done;

   add_quick_extend_logic_ops add_quick_extend_logic_ops_inst (
      .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
      .ext_word0(ext_word0), .ext_word1(ext_word1), .mem_src_data(mem_src_data),
      .mem_dst_data(mem_dst_data), .reg_wr_en(reg_wr_en), .reg_wr_addr_sel(reg_wr_addr_sel),
      .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .reg_rd_addr_sel(reg_rd_addr_sel),
      .reg_rd_idx(reg_rd_idx), .reg_rd_data_q(reg_rd_data_q), .done_q(done_q),
      .illegal_q(illegal_q), .mem_wr_q(mem_wr_q), .result_q(result_q),
      .src_addr_q(src_addr_q), .dst_addr_q(dst_addr_q), .ccr_q(ccr_q)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Value comparison
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   // Register load
   task automatic wreg(input logic asel, input logic [2:0] idx, input logic [31:0] d);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_wr_addr_sel = asel;
      reg_wr_idx = idx;
      reg_wr_data = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask : wreg

   // Register readback
   task automatic rreg(input logic asel, input logic [2:0] idx, input logic [31:0] exp);
      @(negedge clk);
      reg_rd_addr_sel = asel;
      reg_rd_idx = idx;
      @(negedge clk);
      cmp(reg_rd_data_q, exp, "register");
   endtask : rreg

   // One instruction and its status
   task automatic ex(input logic [15:0] op, input logic [15:0] e0, input logic [15:0] e1,
                     input logic [31:0] ms, input logic [31:0] md, input logic ill,
                     input logic mw, input logic [4:0] cc);
      @(negedge clk);
      instr_valid = 1'b1;
      instr_word = op;
      ext_word0 = e0;
      ext_word1 = e1;
      mem_src_data = ms;
      mem_dst_data = md;
      @(negedge clk);
      instr_valid = 1'b0;
      cmp({31'h0, done_q}, 32'h1, "done");
      cmp({31'h0, illegal_q}, {31'h0, ill}, "illegal");
      cmp({31'h0, mem_wr_q}, {31'h0, mw}, "mem write");
      cmp({27'h0, ccr_q}, {27'h0, cc}, "flags");
   endtask : ex

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   initial begin
      #(40 * 3000);
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end

   initial begin
      err_total = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      ext_word0 = 16'h0000;
      ext_word1 = 16'h0000;
      mem_src_data = 32'h00000000;
      mem_dst_data = 32'h00000000;
      reg_wr_en = 1'b0;
      reg_wr_addr_sel = 1'b0;
      reg_wr_idx = 3'h0;
      reg_wr_data = 32'h00000000;
      reg_rd_addr_sel = 1'b0;
      reg_rd_idx = 3'h0;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      cmp({27'h0, ccr_q}, 32'h0, "reset flags");
      wreg(1'b0, 3'h0, 32'h0000007F);
      wreg(1'b0, 3'h1, 32'h0000FFF8);
      wreg(1'b1, 3'h0, 32'h0000FFFF);
      wreg(1'b0, 3'h2, 32'hAAAAAA01);
      wreg(1'b0, 3'h3, 32'h00000001);
      wreg(1'b0, 3'h4, 32'h80000000);
      wreg(1'b0, 3'h5, 32'h000000FF);
      wreg(1'b0, 3'h6, 32'h00000000);
      wreg(1'b0, 3'h7, 32'hF0F0F0F0);
      wreg(1'b1, 3'h1, 32'h00000100);
      // Quick additions
      ex(16'h5200, 16'h0, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h0A);
      rreg(1'b0, 3'h0, 32'h00000080);
      ex(16'h5041, 16'h0, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h15);
      rreg(1'b0, 3'h1, 32'h00000000);
      ex(16'h5248, 16'h0, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h15);
      rreg(1'b1, 3'h0, 32'h00010000);
      ex(16'h5208, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h15);
      ex(16'h523C, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h15);
      // Immediate additions at each size
      ex(16'h0602, 16'h12FF, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h15);
      rreg(1'b0, 3'h2, 32'hAAAAAA00);
      ex(16'h0643, 16'h1234, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h00);
      rreg(1'b0, 3'h3, 32'h00001235);
      ex(16'h0684, 16'h8000, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h17);
      rreg(1'b0, 3'h4, 32'h00000000);
      ex(16'h06C0, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h17);
      // Extend add with zero result keeps Z
      ex(16'hDB06, 16'h0, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h15);
      rreg(1'b0, 3'h5, 32'h00000000);
      // Conjunction forms
      ex(16'hC487, 16'h0, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h18);
      rreg(1'b0, 3'h2, 32'hA0A0A000);
      ex(16'hC550, 16'h0, 16'h0, 32'h0, 32'h0000FFFF, 1'b0, 1'b1, 5'h18);
      cmp(result_q, 32'h0000A000, "and result");
      ex(16'hC408, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h18);
      ex(16'hC500, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h18);
      ex(16'hC53C, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h18);
      ex(16'hC4C0, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h18);
      ex(16'hC43C, 16'h00FF, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h14);
      // Extend add with nonzero result clears Z
      wreg(1'b0, 3'h5, 32'h00000001);
      wreg(1'b0, 3'h6, 32'h00000002);
      ex(16'hDB06, 16'h0, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h00);
      ex(16'hD585, 16'h0, 16'h0, 32'h0, 32'h0, 1'b0, 1'b0, 5'h08);
      rreg(1'b0, 3'h2, 32'hA0A0A004);
      // Memory to memory extend add
      ex(16'hD308, 16'h0, 16'h0, 32'h10, 32'h20, 1'b0, 1'b1, 5'h00);
      cmp(result_q, 32'h00000030, "extend result");
      cmp(src_addr_q, 32'h0000FFFF, "source address");
      cmp(dst_addr_q, 32'h000000FF, "destination address");
      // Quick add to memory and conjunction with a memory source
      ex(16'h5890, 16'h0, 16'h0, 32'h0, 32'hFFFFFFFC, 1'b0, 1'b1, 5'h15);
      cmp(result_q, 32'h00000000, "quick result");
      ex(16'hC090, 16'h0, 16'h0, 32'h000000F0, 32'h0, 1'b0, 1'b0, 5'h10);
      rreg(1'b0, 3'h0, 32'h00000080);
      ex(16'h4E71, 16'h0, 16'h0, 32'h0, 32'h0, 1'b1, 1'b0, 5'h10);
      final_report();
   end
endmodule : add_quick_extend_logic_ops_tb
